// >>> design/dac_link_map.svh
// Function
// - Write carries command nibble then twelve code bits
// - Registers commit at acknowledge falling clock edge
// - Aborted write changes nothing; master resends
// - Command 1100 loads input and converter registers
// - Command 1101 loads input register only
// - Command 1110 loads input, old input to converter
// - Command 1111 copies input to converter, ignores data
// - Command 10xx is read request, data ignored
// - Command 01xx writes code bits 11:10 to shutdown
// - Read direction bit sends converter register out
// - Read sends byte, waits master ack, second byte
// - Device pulls data low on ninth pulse
// - General call address is not answered
// - Seven-bit addressing only, no ten-bit formats
// - Address mismatch stops clocking the core
// - Only a new START resumes core clocking
// - Address bits 6:1 fixed, bit 0 from strap pin
// - Own address acknowledged by one low bit
// - Address byte LSB selects write or read
// - Registers kept through power-down; output restored
`ifndef DAC_LINK_MAP_SVH
`define DAC_LINK_MAP_SVH
`define CMD_LOAD_BOTH 4'hC
`define CMD_LOAD_INPUT 4'hD
`define CMD_LOAD_SHIFT 4'hE
`define CMD_UPDATE 4'hF
`define CMD_READ_TOP 2'h2
`define CMD_SHDN_TOP 2'h1
`define SHDN_RESET 2'h3
`define CODE_RESET 12'h000
`define ADDR_UPPER_DEFAULT 6'h08
`define GENERAL_CALL 7'h00
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_START 4'hF
`define SCL_HALF_DIV 8'h0A
`endif

// >>> design/dac_link_pkg.sv
package dac_link_pkg;
	typedef enum logic [2:0] {
		SL_IDLE, SL_ADDR, SL_WRITE, SL_READ, SL_GATED
	} slave_state_t;
	typedef enum logic [3:0] {
		MS_IDLE, MS_START, MS_BIT_LO, MS_BIT_HI, MS_STOP_LO, MS_STOP_HI, MS_DONE
	} master_state_t;
endpackage

// >>> design/dac_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Open-drain bus: each end pulls low when its enable is low
interface dac_link_if;
	logic scl_oe_n_m;
	logic sda_oe_n_m;
	logic sda_oe_n_s;
	logic scl_o_m;
	logic sda_o_m;
	logic sda_o_s;
	wire scl = scl_oe_n_m ? 1'b1 : scl_o_m;
	wire sda = (sda_oe_n_m ? 1'b1 : sda_o_m) & (sda_oe_n_s ? 1'b1 : sda_o_s);
	modport device(input scl, input sda, output sda_o_s, output sda_oe_n_s);
	modport master(input scl, input sda, output scl_o_m, output scl_oe_n_m,
		output sda_o_m, output sda_oe_n_m);
endinterface
`default_nettype wire

// >>> design/dac_two_wire_command_slave.sv
`include "dac_link_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_two_wire_command_slave #(
	parameter logic [5:0] ADDR_UPPER = `ADDR_UPPER_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	dac_link_if.device bus,
	input wire logic addr_select_pin,
	output logic [11:0] input_code,
	output logic [11:0] converter_code,
	output logic shutdown_select_hi,
	output logic shutdown_select_lo,
	output logic core_clock_enabled
);
	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	logic [1:0] scl_sync_reg, sda_sync_reg, strap_sync_reg;
	logic scl_prev_reg, sda_prev_reg;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			strap_sync_reg <= 2'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			strap_sync_reg <= {strap_sync_reg[0], addr_select_pin};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end
	logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen;
	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign scl_rise = scl_s && !scl_prev_reg;
	assign scl_fall = !scl_s && scl_prev_reg;
	// SDA moves while SCL stays high mark frame edges
	assign start_seen = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_seen = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

	// ----------------------------------------
	// Bit level state machine
	// ----------------------------------------
	dac_link_pkg::slave_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [3:0] cmd_reg;
	logic [3:0] hi_code_reg;
	logic byte_idx_reg;
	logic [6:0] own_addr;
	logic [15:0] tx_word;
	assign own_addr = {ADDR_UPPER, strap_sync_reg[1]};
	assign tx_word = {4'h0, converter_code};
	// Strap is sampled live; it is meant to be fixed by wiring
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg <= dac_link_pkg::SL_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			cmd_reg <= 4'h0;
			hi_code_reg <= 4'h0;
			byte_idx_reg <= 1'b0;
		end else if (start_seen) begin
			state_reg <= dac_link_pkg::SL_ADDR;
			// The START's own clock fall is no bit; it wraps the count to zero
			bit_cnt_reg <= `BIT_START;
			byte_idx_reg <= 1'b0;
		end else if (stop_seen) begin
			state_reg <= dac_link_pkg::SL_IDLE;
		end else if (scl_rise && state_reg != dac_link_pkg::SL_IDLE
				&& state_reg != dac_link_pkg::SL_GATED
				&& bit_cnt_reg <= `BIT_LAST) begin
			shift_reg <= {shift_reg[6:0], sda_s};
		end else if (scl_rise && state_reg == dac_link_pkg::SL_READ
				&& bit_cnt_reg == `BIT_ACK && sda_s) begin
			state_reg <= dac_link_pkg::SL_IDLE;
		end else if (scl_fall) begin
			case (state_reg)
				dac_link_pkg::SL_ADDR: begin
					if (bit_cnt_reg == `BIT_LAST) begin
						// Mismatch or general call: core clock switches off
						if (shift_reg[7:1] != own_addr
								|| shift_reg[7:1] == `GENERAL_CALL) begin
							state_reg <= dac_link_pkg::SL_GATED;
						end
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (bit_cnt_reg == `BIT_ACK) begin
						bit_cnt_reg <= 4'h0;
						state_reg <= shift_reg[0] ? dac_link_pkg::SL_READ
							: dac_link_pkg::SL_WRITE;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				dac_link_pkg::SL_WRITE, dac_link_pkg::SL_READ: begin
					if (bit_cnt_reg == `BIT_ACK) begin
						bit_cnt_reg <= 4'h0;
						byte_idx_reg <= !byte_idx_reg;
						if (!byte_idx_reg) begin
							cmd_reg <= shift_reg[7:4];
							hi_code_reg <= shift_reg[3:0];
						end
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register commit at second byte ack end
	// ----------------------------------------
	logic commit;
	logic [11:0] new_code;
	assign commit = scl_fall && state_reg == dac_link_pkg::SL_WRITE
		&& bit_cnt_reg == `BIT_ACK && byte_idx_reg;
	assign new_code = {hi_code_reg, shift_reg};
	// Power-down never touches the code registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			input_code <= `CODE_RESET;
			converter_code <= `CODE_RESET;
			shutdown_select_hi <= 1'(`SHDN_RESET >> 1);
			shutdown_select_lo <= 1'(`SHDN_RESET);
		end else if (commit) begin
			case (cmd_reg)
				`CMD_LOAD_BOTH: begin
					input_code <= new_code;
					converter_code <= new_code;
				end
				`CMD_LOAD_INPUT: input_code <= new_code;
				`CMD_LOAD_SHIFT: begin
					input_code <= new_code;
					converter_code <= input_code;
				end
				`CMD_UPDATE: converter_code <= input_code;
				default: begin
					if (cmd_reg[3:2] == `CMD_SHDN_TOP) begin
						shutdown_select_hi <= hi_code_reg[3];
						shutdown_select_lo <= hi_code_reg[2];
					end
					// Read request (10xx): nothing stored
				end
			endcase
		end
	end

	// ----------------------------------------
	// SDA drive: ack and read-back bits
	// ----------------------------------------
	// Drive decision for the slot that follows the next clock fall
	logic drive_low_next;
	assign drive_low_next = drive_low_after(state_reg, bit_cnt_reg, shift_reg, own_addr,
		tx_word, byte_idx_reg);
	// Pull SDA low only after SCL falls so data is stable while high; START, STOP and idle release it
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bus.sda_oe_n_s <= 1'b1;
		end else if (start_seen || stop_seen) begin
			bus.sda_oe_n_s <= 1'b1;
		end else if (scl_fall || state_reg == dac_link_pkg::SL_IDLE) begin
			bus.sda_oe_n_s <= !drive_low_next;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bus.sda_o_s <= 1'b0;
			core_clock_enabled <= 1'b0;
		end else begin
			bus.sda_o_s <= 1'b0;
			core_clock_enabled <= state_reg != dac_link_pkg::SL_GATED
				&& state_reg != dac_link_pkg::SL_IDLE;
		end
	end

	// Next-bit drive decision, looked ahead one falling edge
	function automatic logic drive_low_after(
		input dac_link_pkg::slave_state_t st,
		input logic [3:0] cnt,
		input logic [7:0] sh,
		input logic [6:0] addr,
		input logic [15:0] word,
		input logic idx
	);
		logic r;
		r = 1'b0;
		if (st == dac_link_pkg::SL_ADDR && cnt == `BIT_LAST) begin
			r = sh[7:1] == addr && sh[7:1] != `GENERAL_CALL;
		end else if (st == dac_link_pkg::SL_WRITE && cnt == `BIT_LAST) begin
			r = 1'b1;
		end else if (st == dac_link_pkg::SL_ADDR && cnt == `BIT_ACK && sh[0]) begin
			r = !word[15];
		end else if (st == dac_link_pkg::SL_READ && cnt == `BIT_ACK) begin
			r = !idx && !word[7];
		end else if (st == dac_link_pkg::SL_READ && cnt < `BIT_LAST) begin
			r = !word[{!idx, ~(cnt[2:0] + 3'h1)}];
		end
		return r;
	endfunction
endmodule
`default_nettype wire

// >>> design/dac_link_master.sv
`include "dac_link_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dac_link_master #(
	parameter logic [7:0] HALF_DIV = `SCL_HALF_DIV
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	dac_link_if.master bus,
	input wire logic req_valid,
	input wire logic [6:0] req_addr,
	input wire logic req_read,
	input wire logic [3:0] req_command,
	input wire logic [11:0] req_code,
	output logic busy,
	output logic done,
	output logic nack_seen,
	output logic [11:0] read_code
);
	// ----------------------------------------
	// SCL timebase: one enable per half period
	// ----------------------------------------
	logic [7:0] div_reg;
	logic tick;
	assign tick = div_reg == 8'h00;
	always_ff @(posedge clk_sys) begin
		if (!reset_n || tick) div_reg <= HALF_DIV;
		else div_reg <= div_reg - 8'h01;
	end

	// Data line is a pin: two flops before the sequencer reads it
	logic [1:0] sda_sync_reg;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sda_sync_reg <= 2'h3;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	// ----------------------------------------
	// Frame sequencer: 3 bytes each with ack slot
	// ----------------------------------------
	dac_link_pkg::master_state_t st_reg;
	logic [26:0] tx_reg;
	logic [4:0] bit_reg;
	logic [1:0] byte_reg;
	logic rd_reg;
	logic [15:0] rx_reg;
	logic [3:0] slot;
	assign slot = 4'(bit_reg % 5'd9);
	// Frame: address+dir, command+code hi, code lo
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_reg <= dac_link_pkg::MS_IDLE;
			tx_reg <= 27'h0;
			bit_reg <= 5'h0;
			byte_reg <= 2'h0;
			rd_reg <= 1'b0;
			rx_reg <= 16'h0;
			bus.scl_oe_n_m <= 1'b1;
			bus.sda_oe_n_m <= 1'b1;
			bus.scl_o_m <= 1'b0;
			bus.sda_o_m <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			nack_seen <= 1'b0;
			read_code <= 12'h000;
		end else begin
			done <= 1'b0;
			case (st_reg)
				dac_link_pkg::MS_IDLE: if (req_valid) begin
					// Only seven-bit addresses are formed
					tx_reg <= {req_addr, req_read, 1'b1, req_command, req_code[11:8],
						1'b1, req_code[7:0], 1'b1};
					rd_reg <= req_read;
					busy <= 1'b1;
					nack_seen <= 1'b0;
					bit_reg <= 5'h0;
					byte_reg <= 2'h0;
					st_reg <= dac_link_pkg::MS_START;
				end
				dac_link_pkg::MS_START: if (tick) begin
					bus.sda_oe_n_m <= 1'b0;
					st_reg <= dac_link_pkg::MS_BIT_LO;
				end
				dac_link_pkg::MS_BIT_LO: if (tick) begin
					bus.scl_oe_n_m <= 1'b0;
					// Release SDA on the slave's slots; ack read byte 1
					if (slot == `BIT_ACK)
						bus.sda_oe_n_m <= !(rd_reg && byte_reg == 2'h1);
					else if (rd_reg && byte_reg != 2'h0)
						bus.sda_oe_n_m <= 1'b1;
					else
						bus.sda_oe_n_m <= tx_reg[26];
					st_reg <= dac_link_pkg::MS_BIT_HI;
				end
				dac_link_pkg::MS_BIT_HI: if (tick) begin
					bus.scl_oe_n_m <= 1'b1;
					tx_reg <= {tx_reg[25:0], 1'b1};
					if (slot == `BIT_ACK && !(rd_reg && byte_reg != 2'h0) && sda_sync_reg[1])
						nack_seen <= 1'b1;
					if (slot != `BIT_ACK && rd_reg && byte_reg != 2'h0)
						rx_reg <= {rx_reg[14:0], sda_sync_reg[1]};
					if (slot == `BIT_ACK) begin
						byte_reg <= byte_reg + 2'h1;
						bit_reg <= 5'h0;
						if (byte_reg == 2'h2) st_reg <= dac_link_pkg::MS_STOP_LO;
						else st_reg <= dac_link_pkg::MS_BIT_LO;
					end else begin
						bit_reg <= bit_reg + 5'h1;
						st_reg <= dac_link_pkg::MS_BIT_LO;
					end
				end
				dac_link_pkg::MS_STOP_LO: if (tick) begin
					bus.scl_oe_n_m <= 1'b0;
					bus.sda_oe_n_m <= 1'b0;
					st_reg <= dac_link_pkg::MS_STOP_HI;
				end
				dac_link_pkg::MS_STOP_HI: if (tick) begin
					bus.scl_oe_n_m <= 1'b1;
					st_reg <= dac_link_pkg::MS_DONE;
				end
				default: if (tick) begin
					bus.sda_oe_n_m <= 1'b1;
					busy <= 1'b0;
					done <= 1'b1;
					if (rd_reg) read_code <= rx_reg[11:0];
					st_reg <= dac_link_pkg::MS_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> testbench/dac_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the shared two-wire lines and both ends' outputs
module dac_link_assertions (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_oe_n_s,
	input wire logic scl_oe_n_m,
	input wire logic [11:0] input_code,
	input wire logic [11:0] converter_code,
	input wire logic shutdown_select_hi,
	input wire logic shutdown_select_lo,
	input wire logic core_clock_enabled,
	input wire logic done,
	input wire logic busy
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// Commit timing and gating of the core
	// ----------------------------------------
	// Loads land only while the clock line is low, after the ack slot
	input_commit_a: assert property ($changed(input_code) |-> !scl)
		else $error("input code changed with clock line high");
	conv_commit_a: assert property ($changed(converter_code) |-> !scl)
		else $error("converter code changed with clock line high");
	shutdown_commit_a: assert property ($changed({shutdown_select_hi,
		shutdown_select_lo}) |-> !scl)
		else $error("shutdown select changed with clock line high");
	gated_hold_a: assert property (!core_clock_enabled |=> $stable(converter_code)
		&& $stable(input_code))
		else $error("codes moved while core clock was off");
	gated_quiet_a: assert property (!core_clock_enabled |-> sda_oe_n_s)
		else $error("device pulled data while core clock was off");
	// A START leaves the clock high for a half period, so reopening sees it high
	start_reopen_a: assert property ($rose(core_clock_enabled) |-> scl && !sda)
		else $error("core clock reopened outside a START");

	// ----------------------------------------
	// Line discipline of each end
	// ----------------------------------------
	// Data edges under a high clock would read as START or STOP
	ack_edge_a: assert property (($fell(sda_oe_n_s) || $rose(sda_oe_n_s)) |-> !scl)
		else $error("device moved data while clock high");
	ack_bound_a: assert property ($fell(sda_oe_n_s) |-> ##[1:400] sda_oe_n_s)
		else $error("device held data low too long");
	done_pulse_a: assert property (done |=> !done && !busy)
		else $error("done held longer than one cycle");
	clock_owner_a: assert property (!scl_oe_n_m |-> busy)
		else $error("master drove clock while idle");
endmodule
`default_nettype wire

// >>> testbench/test_dac_two_wire_command_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_dac_two_wire_command_slave;
	localparam logic [5:0] UPPER = 6'h08;
	typedef struct packed {
		logic [3:0] cmd;
		logic [11:0] code;
		logic [11:0] in_exp;
		logic [11:0] cv_exp;
		logic [1:0] sd_exp;
	} row_t;
	logic clk_sys, reset_n, addr_select_pin, req_valid, req_read;
	logic busy, done, nack_seen, core_clock_enabled, shutdown_select_hi, shutdown_select_lo;
	logic [6:0] req_addr;
	logic [3:0] req_command;
	logic [11:0] req_code, read_code, input_code, converter_code;
	int fail_count = 0;
	int checks = 0;
	// Writes in order; each row expects the state left by itself and all rows before it
	row_t rows [9] = '{
		'{4'hC, 12'h123, 12'h123, 12'h123, 2'h3}, '{4'hD, 12'h456, 12'h456, 12'h123, 2'h3},
		'{4'hE, 12'h789, 12'h789, 12'h456, 2'h3}, '{4'hF, 12'hABC, 12'h789, 12'h789, 2'h3},
		'{4'h4, 12'h000, 12'h789, 12'h789, 2'h0}, '{4'h5, 12'h400, 12'h789, 12'h789, 2'h1},
		'{4'h6, 12'h800, 12'h789, 12'h789, 2'h2}, '{4'h7, 12'hC00, 12'h789, 12'h789, 2'h3},
		'{4'h8, 12'hFFF, 12'h789, 12'h789, 2'h3}};

	dac_link_if i_dac_link_if();
	dac_two_wire_command_slave #(.ADDR_UPPER(UPPER)) i_dac_two_wire_command_slave (
		.clk_sys(clk_sys), .reset_n(reset_n), .bus(i_dac_link_if),
		.addr_select_pin(addr_select_pin), .input_code(input_code),
		.converter_code(converter_code), .shutdown_select_hi(shutdown_select_hi),
		.shutdown_select_lo(shutdown_select_lo), .core_clock_enabled(core_clock_enabled));
	dac_link_master #(.HALF_DIV(8'h0A)) i_dac_link_master (
		.clk_sys(clk_sys), .reset_n(reset_n), .bus(i_dac_link_if), .req_valid(req_valid),
		.req_addr(req_addr), .req_read(req_read), .req_command(req_command),
		.req_code(req_code), .busy(busy), .done(done), .nack_seen(nack_seen),
		.read_code(read_code));
	dac_link_assertions i_dac_link_assertions (
		.clk_sys(clk_sys), .reset_n(reset_n), .scl(i_dac_link_if.scl),
		.sda(i_dac_link_if.sda), .sda_oe_n_s(i_dac_link_if.sda_oe_n_s),
		.scl_oe_n_m(i_dac_link_if.scl_oe_n_m), .input_code(input_code),
		.converter_code(converter_code), .shutdown_select_hi(shutdown_select_hi),
		.shutdown_select_lo(shutdown_select_lo), .core_clock_enabled(core_clock_enabled),
		.done(done), .busy(busy));

	// ----------------------------------------
	// Clock, comparison and closing
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One whole frame through the master; bounded waits so a hang cannot stall
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [3:0] c,
		input logic [11:0] d);
		int n;
		n = 0;
		@(negedge clk_sys);
		req_addr = a;
		req_read = rd;
		req_command = c;
		req_code = d;
		req_valid = 1'b1;
		while (busy !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		req_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 3000)
			fail_count++;
	endtask

	// Frames take about 700 cycles; fourteen of them fit well inside this
	initial begin
		repeat (40000) @(posedge clk_sys);
		fail_count++;
		print_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		addr_select_pin = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_addr = 7'h00;
		req_command = 4'h0;
		req_code = 12'h000;
		repeat (16) @(negedge clk_sys);
		reset_n = 1'b1;
		check("input_code", input_code, 12'h000);
		check("converter_code", converter_code, 12'h000);
		check("shutdown", {10'h000, shutdown_select_hi, shutdown_select_lo}, 12'h003);
		check("core_clock", {11'h000, core_clock_enabled}, 12'h000);
		repeat (2) @(negedge clk_sys);
		foreach (rows[i]) begin
			xfer({UPPER, 1'b0}, 1'b0, rows[i].cmd, rows[i].code);
			check("ack", {11'h000, nack_seen}, 12'h000);
			check("input_code", input_code, rows[i].in_exp);
			check("converter_code", converter_code, rows[i].cv_exp);
			check("shutdown", {10'h000, shutdown_select_hi, shutdown_select_lo},
				{10'h000, rows[i].sd_exp});
		end
		// Read-back of the converter register
		xfer({UPPER, 1'b0}, 1'b1, 4'h0, 12'h000);
		check("read_code", read_code, 12'h789);
		// Wrong address, then general call: neither may touch the codes
		// Look at the core clock mid-frame, well past the address byte
		fork
			xfer({UPPER ^ 6'h01, 1'b0}, 1'b0, 4'hC, 12'h0AA);
			begin
				repeat (300) @(negedge clk_sys);
				check("core_clock mid", {11'h000, core_clock_enabled}, 12'h000);
			end
		join
		check("mismatch nack", {11'h000, nack_seen}, 12'h001);
		check("core_clock", {11'h000, core_clock_enabled}, 12'h000);
		xfer(7'h00, 1'b0, 4'hC, 12'h0BB);
		check("general nack", {11'h000, nack_seen}, 12'h001);
		check("converter_code", converter_code, 12'h789);
		// Strap pin moves the low address bit
		addr_select_pin = 1'b1;
		repeat (4) @(negedge clk_sys);
		xfer({UPPER, 1'b0}, 1'b0, 4'hC, 12'h0CC);
		check("old address nack", {11'h000, nack_seen}, 12'h001);
		fork
			xfer({UPPER, 1'b1}, 1'b0, 4'hC, 12'h0DD);
			begin
				repeat (300) @(negedge clk_sys);
				check("core_clock mid", {11'h000, core_clock_enabled}, 12'h001);
			end
		join
		check("new address ack", {11'h000, nack_seen}, 12'h000);
		check("converter_code", converter_code, 12'h0DD);
		print_verdict();
	end
endmodule
`default_nettype wire
